// file: logic/timer_compare_regs.vh
// Register map, field layout and mode codes of the compare-output unit
`ifndef TIMER_COMPARE_REGS_VH
`define TIMER_COMPARE_REGS_VH

// Register byte offsets
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h4
`define OFS_CMP_A 4'h8
`define OFS_CMP_B 4'hC

// Control A fields
`define CHA_MODE_HI 7
`define CHA_MODE_LO 6
`define CHB_MODE_HI 5
`define CHB_MODE_LO 4
`define WGS_LO_HI 1
`define WGS_LO_LO 0

// Control B fields
`define WGS_BIT2 3
`define FORCE_A_BIT 7
`define FORCE_B_BIT 6

// Status word layout
`define ST_WAVE_A 0
`define ST_WAVE_B 1
`define ST_DIR_DOWN 2
`define ST_AT_TOP 3

// Output mode codes
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// Waveform generation codes
`define WGM_NORMAL 3'h0
`define WGM_PC_FF 3'h1
`define WGM_CTC 3'h2
`define WGM_FAST_FF 3'h3
`define WGM_PC_OCRA 3'h5
`define WGM_FAST_OCRA 3'h7

// Reset values and constants
`define RST_BYTE 8'h00
`define CNT_MAX 8'hFF
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define RST_WORD 32'h00000000
`define RST_SYNC3 3'h0

// Bus address lane within a word
`define ADR_LANE_HI 1
`define ADR_LANE_LO 0
`define ADR_ALIGNED 2'h0

`endif

// file: logic/compare_channel.v
// One compare-output channel: mode decode, waveform flip-flop and pin override
`timescale 1ns/100ps
`default_nettype none
`include "timer_compare_regs.vh"

module compare_channel (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // Configuration
   input wire [1:0] mode_i,
   input wire is_fast_i,
   input wire is_phase_i,
   input wire toggle_ok_i,
   input wire [7:0] compare_value_i,
   input wire [7:0] top_i,
   // Counter events
   input wire tick_i,
   input wire match_i,
   input wire at_top_i,
   input wire down_i,
   input wire force_i,
   // Pin
   input wire dir_out_i,
   input wire port_data_i,
   output wire pin_o,
   output wire pin_oe_o,
   output wire wave_o
);

   reg wave;
   reg next_wave;
   wire upper_set;
   wire top_case;
   wire connected;

   assign upper_set = mode_i[1];
   // Compare value at top with upper mode bit set
   assign top_case = upper_set && (compare_value_i == top_i) && (is_fast_i || is_phase_i);
   // Either mode bit set takes the pin over, except the toggle code in PWM modes without toggle_ok_i
   assign connected = (mode_i != `COM_OFF) && !((is_fast_i || is_phase_i) && mode_i == `COM_TOGGLE && !toggle_ok_i);

   always @* begin
      next_wave = wave;
      if (tick_i) begin
         if (is_phase_i) begin
            if (mode_i == `COM_TOGGLE) begin
               if (toggle_ok_i && match_i) begin
                  next_wave = ~wave; // R2
               end
            end else if (top_case) begin
               if (at_top_i) begin
                  next_wave = (mode_i == `COM_CLEAR); // R5
               end
            end else if (match_i && mode_i == `COM_CLEAR) begin
               next_wave = down_i; // R3
            end else if (match_i && mode_i == `COM_SET) begin
               next_wave = ~down_i; // R4
            end
         end else if (is_fast_i) begin
            if (mode_i == `COM_TOGGLE) begin
               if (toggle_ok_i && match_i) begin
                  next_wave = ~wave;
               end
            end else if (top_case) begin
               if (at_top_i) begin
                  next_wave = (mode_i == `COM_CLEAR); // R11
               end
            end else if (at_top_i && mode_i == `COM_CLEAR) begin
               next_wave = 1'b1; // R9
            end else if (at_top_i && mode_i == `COM_SET) begin
               next_wave = 1'b0; // R10
            end else if (match_i && mode_i == `COM_CLEAR) begin
               next_wave = 1'b0; // R9
            end else if (match_i && mode_i == `COM_SET) begin
               next_wave = 1'b1; // R10
            end
         end else if (match_i) begin
            case (mode_i) // R8
               `COM_TOGGLE: next_wave = ~wave;
               `COM_CLEAR: next_wave = 1'b0;
               `COM_SET: next_wave = 1'b1;
               default: next_wave = wave;
            endcase
         end
      end
      // Force acts like a match in non-PWM modes only
      if (force_i && !is_fast_i && !is_phase_i) begin
         case (mode_i)
            `COM_TOGGLE: next_wave = ~wave;
            `COM_CLEAR: next_wave = 1'b0;
            `COM_SET: next_wave = 1'b1;
            default: next_wave = wave;
         endcase
      end
   end

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wave <= 1'b0;
      end else begin
         wave <= next_wave;
      end
   end

   // Disconnected channel leaves port data on the pin
   assign pin_o = connected ? wave : port_data_i; // R1 R6 R12
   // Driver only when direction bit says output
   assign pin_oe_o = dir_out_i; // R7
   assign wave_o = wave;

endmodule // compare_channel
`default_nettype wire

// file: logic/timer_compare_output_unit.v
// 8-bit timer with two compare-output channels behind a Wishbone slave
// How it works
// R1 - Phase correct, A mode 00: pin disconnected
// R2 - Phase correct A 01: toggle when select bit2
// R3 - Phase correct A 10: clear up, set down
// R4 - Phase correct A 11: set up, clear down
// R5 - Phase correct A at top: act at top
// R6 - B mode bits 5:4 nonzero take pin; code keeps port data for 01 in PWM modes
// R7 - Drive B only when direction is output
// R8 - Non-PWM B: off, toggle, clear, set
// R9 - Fast B 10: clear match, set top
// R10 - Fast B 11: set match, clear top
// R11 - Fast B compare at top: act at top
// R12 - A mode nonzero takes pin, direction gated; code keeps port data for 01 in PWM without bit2
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "timer_compare_regs.vh"

module timer_compare_output_unit (
   // Clock and reset
   input wire core_clk_i,
   input wire rstn_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output wire wb_err_o,
   // Timer clock enable
   input wire timer_tick_i,
   // Port pins
   input wire dir_a_i,
   input wire dir_b_i,
   input wire port_a_i,
   input wire port_b_i,
   output wire wave_out_a_o,
   output wire wave_out_a_oe_o,
   output wire wave_out_b_o,
   output wire wave_out_b_oe_o
);

   reg rst_meta;
   reg rst_sync;
   reg [7:0] ctrl_a;
   reg [7:0] ctrl_b;
   reg [7:0] compare_value_a;
   reg [7:0] compare_value_b;
   reg [7:0] count;
   reg down;
   reg force_a;
   reg force_b;
   reg [2:0] tick_s;
   reg tick_state;
   wire tick;
   wire [2:0] waveform_generation_select;
   wire [1:0] chan_a_output_mode;
   wire [1:0] chan_b_output_mode;
   wire is_fast;
   wire is_phase;
   wire [7:0] top;
   wire at_top;
   wire at_bottom;
   wire wave_a;
   wire wave_b;
   wire access;
   wire wr;
   wire mapped;

   // Reset release through two flip-flops
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Tick arrives from another domain: three stages, second and third agree
   always @(posedge core_clk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         tick_s <= `RST_SYNC3;
         tick_state <= 1'b0;
      end else begin
         tick_s <= {tick_s[1:0], timer_tick_i};
         if (tick_s[1] == tick_s[2]) begin
            tick_state <= tick_s[2];
         end
      end
   end
   // One count per rising edge of the timer clock
   assign tick = (tick_s[1] == tick_s[2]) && tick_s[2] && !tick_state;

   assign waveform_generation_select = {ctrl_b[`WGS_BIT2], ctrl_a[`WGS_LO_HI:`WGS_LO_LO]};
   assign chan_a_output_mode = ctrl_a[`CHA_MODE_HI:`CHA_MODE_LO];
   assign chan_b_output_mode = ctrl_a[`CHB_MODE_HI:`CHB_MODE_LO]; // R6
   assign is_fast = (waveform_generation_select == `WGM_FAST_FF) ||
                    (waveform_generation_select == `WGM_FAST_OCRA);
   assign is_phase = (waveform_generation_select == `WGM_PC_FF) ||
                     (waveform_generation_select == `WGM_PC_OCRA);
   // Top is compare A in CTC and in the bit2 PWM modes
   assign top = (waveform_generation_select == `WGM_CTC || waveform_generation_select[2]) ?
                compare_value_a : `CNT_MAX;
   assign at_top = (count == top);
   assign at_bottom = (count == `CNT_ZERO);

   // Counter: up-count wraps at top, phase correct turns at top and bottom
   always @(posedge core_clk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         count <= `CNT_ZERO;
         down <= 1'b0;
      end else if (tick) begin
         if (is_phase) begin
            if (!down && at_top) begin
               down <= 1'b1;
               count <= count - `CNT_ONE;
            end else if (down && at_bottom) begin
               down <= 1'b0;
               count <= count + `CNT_ONE;
            end else if (down) begin
               count <= count - `CNT_ONE;
            end else begin
               count <= count + `CNT_ONE;
            end
         end else begin
            down <= 1'b0;
            count <= at_top ? `CNT_ZERO : count + `CNT_ONE;
         end
      end
   end

   compare_channel chan_a (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_sync),
      .mode_i(chan_a_output_mode),
      .is_fast_i(is_fast),
      .is_phase_i(is_phase),
      .toggle_ok_i(waveform_generation_select[2]),
      .compare_value_i(compare_value_a),
      .top_i(top),
      .tick_i(tick),
      .match_i(count == compare_value_a),
      .at_top_i(at_top),
      .down_i(down),
      .force_i(force_a),
      .dir_out_i(dir_a_i),
      .port_data_i(port_a_i),
      .pin_o(wave_out_a_o),
      .pin_oe_o(wave_out_a_oe_o),
      .wave_o(wave_a)
   );

   // Channel B has no toggle in PWM modes
   compare_channel chan_b (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_sync),
      .mode_i(chan_b_output_mode),
      .is_fast_i(is_fast),
      .is_phase_i(is_phase),
      .toggle_ok_i(1'b0),
      .compare_value_i(compare_value_b),
      .top_i(top),
      .tick_i(tick),
      .match_i(count == compare_value_b),
      .at_top_i(at_top),
      .down_i(down),
      .force_i(force_b),
      .dir_out_i(dir_b_i),
      .port_data_i(port_b_i),
      .pin_o(wave_out_b_o),
      .pin_oe_o(wave_out_b_oe_o),
      .wave_o(wave_b)
   );

   // Wishbone slave: one wait-free ack, every offset answers
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = access && wb_we_i && wb_sel_i[0];
   assign mapped = (wb_adr_i[`ADR_LANE_HI:`ADR_LANE_LO] == `ADR_ALIGNED);
   assign wb_err_o = 1'b0;

   always @(posedge core_clk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         ctrl_a <= `RST_BYTE;
         ctrl_b <= `RST_BYTE;
         compare_value_a <= `RST_BYTE;
         compare_value_b <= `RST_BYTE;
         force_a <= 1'b0;
         force_b <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= `RST_WORD;
      end else begin
         wb_ack_o <= access;
         force_a <= 1'b0;
         force_b <= 1'b0;
         if (wr && mapped) begin
            case (wb_adr_i)
               `OFS_CTRL_A: ctrl_a <= wb_dat_i[7:0];
               `OFS_CTRL_B: begin
                  // Force strobes are not stored
                  ctrl_b <= {4'h0, wb_dat_i[`WGS_BIT2], 3'h0};
                  force_a <= wb_dat_i[`FORCE_A_BIT];
                  force_b <= wb_dat_i[`FORCE_B_BIT];
               end
               `OFS_CMP_A: compare_value_a <= wb_dat_i[7:0];
               `OFS_CMP_B: compare_value_b <= wb_dat_i[7:0];
               default: ctrl_a <= ctrl_a;
            endcase
         end
         if (access && !wb_we_i) begin
            case (wb_adr_i)
               `OFS_CTRL_A: wb_dat_o <= {24'h000000, ctrl_a};
               `OFS_CTRL_B: wb_dat_o <= {24'h000000, ctrl_b};
               `OFS_CMP_A: wb_dat_o <= {24'h000000, compare_value_a};
               `OFS_CMP_B: wb_dat_o <= {24'h000000, compare_value_b};
               default: wb_dat_o <= {16'h0000, count, 4'h0, at_top, down, wave_b, wave_a};
            endcase
         end
      end
   end

endmodule // timer_compare_output_unit
`default_nettype wire

// file: bench/timer_compare_monitor.sv
// Port assertions for the compare-output unit
`timescale 1ns/100ps
`default_nettype none
module timer_compare_monitor (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // Pins
   input wire logic dir_a_i,
   input wire logic dir_b_i,
   input wire logic port_a_i,
   input wire logic port_b_i,
   input wire logic wave_out_a_o,
   input wire logic wave_out_a_oe_o,
   input wire logic wave_out_b_o,
   input wire logic wave_out_b_oe_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   logic [7:0] ctl;
   logic sel2;
   wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   // Mode shadow, taken with the request
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctl <= 8'h00;
         sel2 <= 1'b0;
      end else if (wr && wb_adr_i == 4'h0) begin
         ctl <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i == 4'h4) begin
         sel2 <= wb_dat_i[3];
      end
   end
   // Code 01 in PWM without toggle stays off
   wire a_off = ctl[7:6] == 2'h0 || (ctl[7:6] == 2'h1 && ctl[0] && !sel2);
   wire b_off = ctl[5:4] == 2'h0 || (ctl[5:4] == 2'h1 && ctl[0]);
   // New mode may land on either edge of the write, so skip it
   AST_A_PORT: assert property (a_off && !wb_ack_o && !$past(wb_ack_o) |-> wave_out_a_o == port_a_i)
      else $error("A pin not under port control");
   AST_B_PORT: assert property (b_off && !wb_ack_o && !$past(wb_ack_o) |-> wave_out_b_o == port_b_i)
      else $error("B pin not under port control");
   AST_A_OE: assert property (wave_out_a_oe_o == dir_a_i)
      else $error("A enable not the direction bit");
   AST_B_OE: assert property (wave_out_b_oe_o == dir_b_i)
      else $error("B enable not the direction bit");
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack without request");
   AST_NO_ERR: assert property (!wb_err_o)
      else $error("error response raised");
   COV_WRITE: cover property (wb_ack_o && wb_we_i);
   COV_B_RISE: cover property (!b_off && $rose(wave_out_b_o));
   COV_A_FALL: cover property (!a_off && $fell(wave_out_a_o));
endmodule // timer_compare_monitor
bind timer_compare_output_unit timer_compare_monitor mon (.*);
`default_nettype wire

// file: bench/timer_compare_output_unit_test.sv
// Self-checking bench for the compare-output unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module timer_compare_output_unit_test;
   logic core_clk_i;
   logic rstn_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic timer_tick_i = 1'b0;
   logic dir_a_i = 1'b0;
   logic dir_b_i = 1'b1;
   logic port_a_i = 1'b1;
   logic port_b_i = 1'b0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, wb_err_o, wave_out_a_o, wave_out_a_oe_o, wave_out_b_o, wave_out_b_oe_o;
   int errors = 0;
   int tests_run = 0;
   // Register rows: address, write data, read-back byte
   logic [43:0] regs [3] = '{{4'h0, 32'hFFFFFFB1, 8'hB1}, {4'h8, 32'h1234565A, 8'h5A}, {4'hC, 32'h000000A5, 8'hA5}};
   // Forced rows: mode code, resulting level
   logic [2:0] frc [4] = '{3'h7, 3'h4, 3'h3, 3'h2};
   // Sweep rows: control A, compare A, compare B
   logic [23:0] sweep [8] = '{24'h230040, 24'h330040, 24'h2300FF, 24'h130040, 24'h818000, 24'hC18000, 24'h81FF00, 24'h418000};
   timer_compare_output_unit uut (.*);
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // Level after one count, from the count and direction before it
   function automatic logic expv(input logic [1:0] m, input logic f, input logic [7:0] c, input logic [7:0] k,
                                 input logic dn, input logic p);
      if (m == 2'h0 || m == 2'h1) return p;
      if (f) return ((c < k) || (c == 8'hFF)) ^ m[0];
      if (k == 8'hFF) return ~m[0];
      return ((c < k) || (c == k && dn)) ^ m[0];
   endfunction
   task automatic final_report();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         errors++;
         final_report();
      end
   endtask
   // Status word, then one count; pins and directions flip each step
   task automatic step(output logic [7:0] c, output logic dn);
      logic [31:0] r;
      wb(4'h1, 1'b0, 32'h0, r);
      c = r[15:8];
      dn = r[2];
      @(posedge core_clk_i);
      timer_tick_i <= 1'b1;
      port_a_i <= ~port_a_i;
      port_b_i <= ~port_b_i;
      dir_a_i <= ~dir_a_i;
      dir_b_i <= ~dir_b_i;
      repeat (4) @(posedge core_clk_i);
      timer_tick_i <= 1'b0;
      // Wave flop takes the count on the last edge; look one edge later
      @(posedge core_clk_i);
   endtask
   task automatic do_reset();
      logic [31:0] r;
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      `CHK(wave_out_a_o, port_a_i)
      `CHK(wave_out_b_o, port_b_i)
      `CHK(wave_out_a_oe_o, dir_a_i)
      wb(4'h0, 1'b0, 32'h0, r);
      `CHK(r, 32'h0)
   endtask
   initial begin
      logic [31:0] r;
      logic [23:0] w;
      logic [7:0] c;
      logic dn, top, bot, lvl;
      do_reset();
      foreach (regs[i]) begin
         wb(regs[i][43:40], 1'b1, regs[i][39:8], r);
         wb(regs[i][43:40], 1'b0, 32'h0, r);
         `CHK(r, {24'h0, regs[i][7:0]})
      end
      // Misaligned write must leave control untouched
      wb(4'h2, 1'b1, 32'h0, r);
      wb(4'h0, 1'b0, 32'h0, r);
      `CHK(r, 32'hB1)
      foreach (frc[i]) begin
         wb(4'h0, 1'b1, {24'h0, frc[i][2:1], frc[i][2:1], 4'h0}, r);
         wb(4'h4, 1'b1, 32'hC0, r);
         repeat (3) @(posedge core_clk_i);
         `CHK(wave_out_a_o, frc[i][0])
         `CHK(wave_out_b_o, frc[i][0])
      end
      foreach (sweep[i]) begin
         w = sweep[i];
         wb(4'h0, 1'b1, {24'h0, w[23:16]}, r);
         wb(4'h8, 1'b1, {24'h0, w[15:8]}, r);
         wb(4'hC, 1'b1, {24'h0, w[7:0]}, r);
         top = 1'b0;
         bot = 1'b0;
         for (int s = 0; s < (w[17] ? 520 : 1100); s++) begin
            step(c, dn);
            if (bot) begin
               `CHK(wave_out_a_o, expv(w[23:22], w[17], c, w[15:8], dn, port_a_i))
               `CHK(wave_out_b_o, expv(w[21:20], w[17], c, w[7:0], dn, port_b_i))
               `CHK(wave_out_b_oe_o, dir_b_i)
            end
            top = top || c == 8'hFF;
            bot = bot || (top && c == 8'h00);
         end
      end
      // Toggle on match: A in phase correct with bit2, then B in CTC
      wb(4'h4, 1'b1, 32'h08, r);
      wb(4'h8, 1'b1, 32'h10, r);
      wb(4'hC, 1'b1, 32'h08, r);
      for (int s = 0; s < 600; s++) begin
         if (s == 300) begin
            wb(4'h4, 1'b1, 32'h00, r);
            wb(4'h0, 1'b1, 32'h12, r);
         end
         lvl = (s < 300) ? wave_out_a_o : wave_out_b_o;
         step(c, dn);
         if (s < 300) begin
            `CHK(wave_out_a_o, lvl ^ (c == 8'h10))
         end else begin
            `CHK(wave_out_b_o, lvl ^ (c == 8'h08))
         end
      end
      do_reset();
      final_report();
   end
endmodule // timer_compare_output_unit_test
`default_nettype wire
